// file: pkg/drr_defines.svh
// Constants for the sample strobe reset and restart block.
`ifndef DRR_DEFINES_SVH
`define DRR_DEFINES_SVH

// Width of one digitised sample word.
`define DRR_DATA_W 8
// Encode clock periods from sampling edge to output word.
`define DRR_PIPE_LAT 4
// Reset value of the output data word.
`define DRR_DATA_RST 8'h00
// Reset values of the true and complement strobe outputs.
`define DRR_STROBE_P_RST 1'b0
`define DRR_STROBE_N_RST 1'b1
// Core clock period in picoseconds (200 MHz).
`define DRR_CORE_PERIOD_PS 5000
// Longest encode clock period at the lowest sample rate, in nanoseconds.
`define DRR_MAX_ENC_PERIOD_NS 100
// Core cycles without an encode tick before the clock counts as stalled.
`define DRR_STALL_CYCLES ((`DRR_MAX_ENC_PERIOD_NS * 1000) / `DRR_CORE_PERIOD_PS)
// Width of the stall counter.
`define DRR_STALL_W 5

`endif

// file: pkg/drr_pkg.sv
// Types shared by the sample strobe reset and restart block.
package drr_pkg;

  // One-hot states of the encode clock activity monitor.
  typedef enum logic [2:0] {
    MON_IDLE  = 3'b001,
    MON_RUN   = 3'b010,
    MON_STALL = 3'b100
  } mon_state_e;

endpackage : drr_pkg

// file: logic/drr_sync2.sv
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
module drr_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
) ;
  // First stage; only the second stage reads it.
  logic [W-1:0] meta_reg;

  // Both stages follow the input one edge apart.
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end
endmodule : drr_sync2

// file: logic/drr_sample_pipe.sv
// Sample capture register followed by the output pipeline.
`timescale 1ns/1ps
`include "drr_defines.svh"
module drr_sample_pipe #(
  parameter int W = `DRR_DATA_W,
  parameter int LAT = `DRR_PIPE_LAT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
) ;
  // Stage 0 captures the sample; stage LAT is the output word.
  logic [W-1:0] stage_reg [0:LAT];

  // The whole pipe shifts on every rising encode clock edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i <= LAT; i++) begin
        stage_reg[i] <= W'(`DRR_DATA_RST);
      end
    end else begin
      stage_reg[0] <= d;
      for (int i = 1; i <= LAT; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  // The output word comes straight from the last stage.
  assign q = stage_reg[LAT];
endmodule : drr_sample_pipe

// file: logic/drr_strobe_ctrl.sv
// Sample strobe generation with asynchronous reset and phased restart.
`timescale 1ns/1ps
`include "drr_defines.svh"
// Functional notes
// - Low reset input forces strobe to zero.
// - Strobe restarts on reset input rising edge.
// - Tied-high or pulled-up reset means free running.
// - Released with clock low: rise half period.
// - Released with clock high: rise one period.
// - First sample caught by third strobe rise.
// - Strobe toggles at half rate, after falls.
// - Sample output four periods after sampling.
module drr_strobe_ctrl #(
  parameter int DATA_W = `DRR_DATA_W,
  parameter int PIPE_LAT = `DRR_PIPE_LAT,
  parameter int STALL_CYCLES = `DRR_STALL_CYCLES,
  parameter int STALL_W = `DRR_STALL_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic encode_clk,
  input wire logic strobe_reset_n,
  input wire logic [DATA_W-1:0] sample_in,
  output logic [DATA_W-1:0] data_out,
  output logic sample_strobe_p,
  output logic sample_strobe_n,
  output logic strobe_running,
  output logic restart_seen,
  output logic encode_clock_slow
) ;
  // ------------------------------------------------------------------
  // Encode clock domain.
  // ------------------------------------------------------------------

  // Core reset carried into the encode domain.
  logic enc_rst_n;
  // Restart latch: set by the first rising encode edge after release.
  logic arm_reg;
  // True and complement strobe flops.
  logic strobe_p_reg;
  logic strobe_n_reg;
  // Toggles once for each restart, for the core domain.
  logic restart_tgl_reg;
  // Toggles on every rising encode edge, for the core activity monitor.
  logic enc_tick_reg;

  // The core reset is a level, so two flops bring it across.
  drr_sync2 #(
    .W(1)
  ) u_rst_sync (
    .clk(encode_clk),
    .d(rstn),
    .q(enc_rst_n)
  );

  // The latch is cleared without the clock while the reset input is low,
  // and any pulse wide enough to reach the cell clears it. It is set on
  // the first rising edge after release, so the strobe can never toggle
  // on a falling edge that had no rising edge after the release. The
  // release is asynchronous by nature; the half period before the strobe
  // flop reads the latch gives it time to settle.
  always_ff @(posedge encode_clk or negedge strobe_reset_n) begin
    if (!strobe_reset_n) begin
      arm_reg <= 1'b0;
    end else if (!enc_rst_n) begin
      arm_reg <= 1'b0;
    end else begin
      arm_reg <= 1'b1;
    end
  end

  // The strobe flops toggle on falling edges while the latch is set and
  // are forced to their idle levels while the reset input is low. A
  // tied-high or pulled-up input keeps them running freely.
  always_ff @(negedge encode_clk or negedge strobe_reset_n) begin
    if (!strobe_reset_n) begin
      strobe_p_reg <= `DRR_STROBE_P_RST;
      strobe_n_reg <= `DRR_STROBE_N_RST;
    end else if (!enc_rst_n) begin
      strobe_p_reg <= `DRR_STROBE_P_RST;
      strobe_n_reg <= `DRR_STROBE_N_RST;
    end else if (arm_reg) begin
      strobe_p_reg <= ~strobe_p_reg;
      strobe_n_reg <= ~strobe_n_reg;
    end
  end

  // Restart toggle and activity tick for the core domain.
  always_ff @(posedge encode_clk) begin
    if (!enc_rst_n) begin
      restart_tgl_reg <= 1'b0;
      enc_tick_reg <= 1'b0;
    end else begin
      enc_tick_reg <= ~enc_tick_reg;
      if (!arm_reg && strobe_reset_n) begin
        restart_tgl_reg <= ~restart_tgl_reg;
      end
    end
  end

  // The pipeline makes the sample taken on the same edge that sets the
  // latch leave on the fifth rising edge, just before the third strobe
  // rise, which is how the capture side finds the first word.
  drr_sample_pipe #(
    .W(DATA_W),
    .LAT(PIPE_LAT)
  ) u_pipe (
    .clk(encode_clk),
    .rst_n(enc_rst_n),
    .d(sample_in),
    .q(data_out)
  );

  // The strobe outputs come directly from their flops.
  assign sample_strobe_p = strobe_p_reg;
  assign sample_strobe_n = strobe_n_reg;

  // ------------------------------------------------------------------
  // Core clock domain.
  // ------------------------------------------------------------------

  // Synchronised copies of the encode domain levels.
  logic arm_sync;
  logic restart_sync;
  logic tick_sync;
  // Previous synchronised values, for edge detection.
  logic restart_seen_reg;
  logic tick_seen_reg;
  // Activity monitor state and stall counter.
  drr_pkg::mon_state_e mon_state_reg;
  drr_pkg::mon_state_e mon_state_next;
  logic [STALL_W-1:0] stall_cnt_reg;
  logic [STALL_W-1:0] stall_cnt_next;
  // A new tick or a new restart seen in this core cycle.
  logic tick_event;
  logic restart_event;
  // The stall count has reached its limit.
  logic stall_limit;

  // Three levels cross together; each bit is independent.
  drr_sync2 #(
    .W(3)
  ) u_core_sync (
    .clk(core_clk),
    .d({arm_reg, restart_tgl_reg, enc_tick_reg}),
    .q({arm_sync, restart_sync, tick_sync})
  );

  // Edges of the synchronised toggles mark encode domain events.
  assign tick_event = tick_sync ^ tick_seen_reg;
  assign restart_event = restart_sync ^ restart_seen_reg;
  assign stall_limit = (stall_cnt_reg == STALL_W'(STALL_CYCLES));

  // Edge detector history and the registered status levels. During reset
  // the history follows its input, so no stale toggle looks like an event.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tick_seen_reg <= tick_sync;
      restart_seen_reg <= restart_sync;
      strobe_running <= 1'b0;
    end else begin
      tick_seen_reg <= tick_sync;
      restart_seen_reg <= restart_sync;
      strobe_running <= arm_sync;
    end
  end

  // A restart is reported for exactly one core cycle, never during reset.
  assign restart_seen = restart_event && rstn;

  // The monitor watches for an encode clock that has stopped or slowed
  // below the lowest sample rate, because a restart is only defined
  // while the clock keeps running.
  always_comb begin
    mon_state_next = mon_state_reg;
    stall_cnt_next = stall_cnt_reg;
    case (mon_state_reg)
      // Wait for the first tick after reset.
      drr_pkg::MON_IDLE: begin
        if (tick_event) begin
          mon_state_next = drr_pkg::MON_RUN;
          stall_cnt_next = '0;
        end
      end
      // Count core cycles between ticks.
      drr_pkg::MON_RUN: begin
        if (tick_event) begin
          stall_cnt_next = '0;
        end else if (stall_limit) begin
          mon_state_next = drr_pkg::MON_STALL;
        end else begin
          stall_cnt_next = stall_cnt_reg + STALL_W'(1);
        end
      end
      // Leave the stall state on the next tick.
      drr_pkg::MON_STALL: begin
        if (tick_event) begin
          mon_state_next = drr_pkg::MON_RUN;
          stall_cnt_next = '0;
        end
      end
      default: begin
        mon_state_next = drr_pkg::MON_IDLE;
        stall_cnt_next = '0;
      end
    endcase
  end

  // Monitor state register.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mon_state_reg <= drr_pkg::MON_IDLE;
      stall_cnt_reg <= '0;
    end else begin
      mon_state_reg <= mon_state_next;
      stall_cnt_reg <= stall_cnt_next;
    end
  end

  // The stall flag is the monitor state, read from its flop.
  assign encode_clock_slow = (mon_state_reg == drr_pkg::MON_STALL);

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------

  // Helper: the sample taken on the edge that sets the latch.
  logic [DATA_W-1:0] first_sample_reg;
  // Helper: strobe rises seen since release, saturating at three.
  logic [1:0] rise_cnt_reg;
  // Helper: filled pipeline stages since the encode domain reset.
  logic [2:0] fill_cnt_reg;

  // The first sample is caught on the edge that sets the latch.
  always_ff @(posedge encode_clk or negedge strobe_reset_n) begin
    if (!strobe_reset_n) begin
      first_sample_reg <= '0;
    end else if (!arm_reg) begin
      first_sample_reg <= sample_in;
    end
  end

  // Rises are counted on the falling edges that make them.
  always_ff @(negedge encode_clk or negedge strobe_reset_n) begin
    if (!strobe_reset_n) begin
      rise_cnt_reg <= 2'h0;
    end else if (arm_reg && !strobe_p_reg && rise_cnt_reg != 2'h3) begin
      rise_cnt_reg <= rise_cnt_reg + 2'h1;
    end
  end

  // Pipeline history is trusted once five edges have passed.
  always_ff @(posedge encode_clk) begin
    if (!enc_rst_n) begin
      fill_cnt_reg <= 3'h0;
    end else if (fill_cnt_reg != 3'h5) begin
      fill_cnt_reg <= fill_cnt_reg + 3'h1;
    end
  end

  // Release leads to a latch set, then a strobe rise half a period on.
  sequence s_latch_set;
    !arm_reg ##1 arm_reg;
  endsequence

  property p_hold_low;
    @(posedge encode_clk) disable iff (!enc_rst_n)
      !strobe_reset_n |-> !sample_strobe_p && sample_strobe_n;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("strobe not held low during reset input");

  property p_arm_only_released;
    @(negedge encode_clk) disable iff (!enc_rst_n)
      arm_reg |-> strobe_reset_n;
  endproperty
  a_arm_only_released: assert property (p_arm_only_released)
    else $error("restart latch set while reset input low");

  property p_free_toggle;
    @(negedge encode_clk) disable iff (!enc_rst_n)
      (arm_reg && strobe_reset_n)
        ##1 (arm_reg && strobe_reset_n && $stable(restart_tgl_reg))
        |-> sample_strobe_p != $past(sample_strobe_p);
  endproperty
  a_free_toggle: assert property (p_free_toggle)
    else $error("strobe missed a falling edge toggle");

  property p_first_rise;
    @(negedge encode_clk) disable iff (!enc_rst_n || !strobe_reset_n)
      s_latch_set |-> ##1 sample_strobe_p;
  endproperty
  a_first_rise: assert property (p_first_rise)
    else $error("first strobe rise late after latch set");

  property p_no_early_rise;
    @(negedge encode_clk) disable iff (!enc_rst_n || !strobe_reset_n)
      !arm_reg |=> !sample_strobe_p;
  endproperty
  a_no_early_rise: assert property (p_no_early_rise)
    else $error("strobe rose before a rising clock edge");

  property p_complement;
    @(posedge encode_clk) disable iff (!enc_rst_n)
      sample_strobe_n == !sample_strobe_p;
  endproperty
  a_complement: assert property (p_complement)
    else $error("strobe outputs not complementary");

  property p_latency;
    @(posedge encode_clk) disable iff (!enc_rst_n)
      fill_cnt_reg == 3'h5 |-> data_out == $past(sample_in, 5);
  endproperty
  a_latency: assert property (p_latency)
    else $error("output word not four periods after sampling");

  property p_third_rise;
    @(negedge encode_clk) disable iff (!enc_rst_n || !strobe_reset_n)
      (arm_reg && !sample_strobe_p && rise_cnt_reg == 2'h2)
        |-> data_out == first_sample_reg;
  endproperty
  a_third_rise: assert property (p_third_rise)
    else $error("first sample not at third strobe rise");

  property p_stall_flag;
    @(posedge core_clk) disable iff (!rstn)
      (mon_state_reg == drr_pkg::MON_RUN && stall_limit && !tick_event)
        |=> encode_clock_slow ##1 (encode_clock_slow || $past(tick_event));
  endproperty
  a_stall_flag: assert property (p_stall_flag)
    else $error("stalled encode clock not flagged");

endmodule : drr_strobe_ctrl

// file: tb/capture_model.sv
// Capture-side partner: pulls the strobe reset pin, logs strobe rises.
`timescale 1ns/1ps
module capture_model (
  input wire logic encode_clk,
  input wire logic sample_strobe_p,
  input wire logic [7:0] sample_in,
  input wire logic [7:0] data_out,
  output logic pull_low
);
  int falls; // Encode falls since the last release.
  int rises; // Strobe rises since the last release.
  int first_fall; // Fall count at the first strobe rise.
  logic armed; // Set from release until the next encode rise.
  logic [7:0] word_n; // Word sampled on the first rise after release.
  logic [7:0] word3; // Word present at the third strobe rise.

  // The pin starts released, so the pull-up lets the strobe run.
  initial begin
    pull_low = 1'b0;
    armed = 1'b0;
  end

  // Pull the pin low for a pulse that ends in the asked clock phase.
  task automatic restart(input bit hi, input int width);
    if (hi) begin
      @(posedge encode_clk);
    end else begin
      @(negedge encode_clk);
    end
    #20;
    pull_low = 1'b1;
    #(width);
    pull_low = 1'b0;
    falls = 0;
    rises = 0;
    first_fall = 0;
    armed = 1'b1;
  endtask : restart

  // Count encode falls so the first strobe rise can be placed.
  always @(negedge encode_clk) begin
    falls = falls + 1;
  end

  // The first rise after release takes the word that heads the frame.
  always @(posedge encode_clk) begin
    if (armed) begin
      word_n = sample_in;
      armed = 1'b0;
    end
  end

  // The third strobe rise is where the capture side takes that word.
  always @(posedge sample_strobe_p) begin
    rises = rises + 1;
    if (rises == 1) begin
      first_fall = falls;
    end
    if (rises == 3) begin
      word3 = data_out;
    end
  end
endmodule : capture_model

// file: tb/data_ready_reset_restart_tb.sv
// Self-checking bench for the strobe reset and restart block.
`timescale 1ns/1ps
module data_ready_reset_restart_tb;
  typedef struct packed { bit hi; int width; int exp_fall; } row_s;
  row_s rows [4] = '{'{0, 1, 1}, '{1, 1, 2}, '{0, 250, 1}, '{1, 250, 2}};
  logic core_clk = 1'b0; // Core clock, 200 MHz.
  logic encode_clk = 1'b0; // Encode clock, 125 ns period.
  logic rstn; // Core reset, active low.
  logic [7:0] sample_in; // Incrementing sample words.
  logic [7:0] data_out; // Output words.
  logic sp; // True strobe.
  logic sn; // Complement strobe.
  logic running; // Restart latch status.
  logic seen; // Restart pulse.
  logic slow; // Encode clock stall flag.
  logic pull_low; // Partner pulls the reset pin.
  logic prev; // Last strobe level seen.
  tri1 strobe_pin; // Pulled up: a floating pin means free run.
  logic enc_stop = 1'b0; // Holds the encode clock still while high.
  int bad_count = 0;
  int num_checks = 0;
  int seen_cnt = 0; // Restart pulses counted.
  int c0; // Pulse count before a restart.

  // The pin serves only as the strobe reset here.
  assign strobe_pin = pull_low ? 1'b0 : 1'bz;

  drr_strobe_ctrl #(.STALL_CYCLES(30), .STALL_W(5)) dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .encode_clk(encode_clk),
    .strobe_reset_n(strobe_pin),
    .sample_in(sample_in),
    .data_out(data_out),
    .sample_strobe_p(sp),
    .sample_strobe_n(sn),
    .strobe_running(running),
    .restart_seen(seen),
    .encode_clock_slow(slow)
  );

  capture_model model (
    .encode_clk(encode_clk),
    .sample_strobe_p(sp),
    .sample_in(sample_in),
    .data_out(data_out),
    .pull_low(pull_low)
  );

  // Core clock toggles every half period.
  always #2.5 core_clk = ~core_clk;

  // Encode clock, offset so its edges never meet the core edges.
  initial begin
    #1.3;
    forever begin
      #62.5;
      if (!enc_stop) begin
        encode_clk = ~encode_clk;
      end
    end
  end

  // New sample word shortly after each encode rise.
  always @(posedge encode_clk) begin
    #1 sample_in = sample_in + 8'h01;
  end

  // Count restart pulses in the core domain.
  always @(posedge core_clk) begin
    if (seen === 1'b1) begin
      seen_cnt++;
    end
  end

  // While the pin is low the strobe must stay at zero at every fall.
  always @(negedge encode_clk) begin
    if (strobe_pin === 1'b0) begin
      #1 check({sp, sn}, 32'h1);
    end
  end

  // Compare one value and report a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Print the verdict and end the run.
  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // Cut a hang short.
  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  // Main sequence.
  initial begin
    rstn = 1'b0;
    sample_in = 8'h00;
    repeat (16) @(posedge encode_clk);
    #1 check({data_out, sp, sn}, 32'h1);
    @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge encode_clk);
    // Release in each clock phase, after short and long pulses.
    foreach (rows[i]) begin
      c0 = seen_cnt;
      model.restart(rows[i].hi, rows[i].width);
      for (int k = 0; k < 20 && model.rises < 3; k++) begin
        @(posedge encode_clk);
      end
      #1 check(model.first_fall, rows[i].exp_fall);
      check(model.word3, model.word_n);
      check(seen_cnt - c0, 1);
      check(running, 1);
    end
    // Free run: strobe moves on every fall and holds across rises.
    @(negedge encode_clk);
    #1 prev = sp;
    for (int k = 0; k < 6; k++) begin
      @(negedge encode_clk);
      #1 check({sp, sn}, {~prev, prev});
      prev = sp;
      @(posedge encode_clk);
      #1 check(sp, prev);
    end
    check(slow, 0);
    // A stopped encode clock is flagged, and the flag clears on resume.
    @(negedge encode_clk);
    enc_stop = 1'b1;
    repeat (60) @(posedge core_clk);
    #1 check(slow, 1);
    enc_stop = 1'b0;
    repeat (2) @(posedge encode_clk);
    repeat (4) @(posedge core_clk);
    #1 check(slow, 0);
    // Core reset in mid-run returns the outputs to their reset values.
    @(posedge core_clk);
    #1 rstn = 1'b0;
    repeat (4) @(posedge encode_clk);
    #1 check({data_out, sp, sn}, 32'h1);
    // Release again: one restart is reported and the strobe runs.
    c0 = seen_cnt;
    @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge encode_clk);
    #1 check(seen_cnt - c0, 1);
    check(running, 1);
    check(sp ^ sn, 1);
    conclude();
  end
endmodule : data_ready_reset_restart_tb
